// ---- testbench.sv ----
// Self-checking bench for the timer pair.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tpc_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, rd_d = 1'b0;
    tpc_req_t    req = '0;
    logic [15:0] rdata, count1, count2, w;
    logic [15:0] e1 = 16'h0; // Expected first counter.
    logic [3:0]  src = 4'h0; // Source levels, indexed by extended field code.
    logic        idle = 1'b0, gate1 = 1'b0; // Device idle level and first gate input.
    logic [15:0] q[$];       // Expected read data, oldest first.
    int          n_mismatch = 0, checks = 0;
    int          dv[4] = '{1, 8, 64, 256};
    tpc_timer_pair tpc_timer_pair_inst (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .idle(idle),
        .gate_in1(gate1), .gate_in2(1'b0), .first_timer_clock_pin(src[3]), .second_timer_clock_pin(src[1]),
        .low_power_rc_osc(src[2]), .secondary_osc(src[0]), .count1(count1), .count2(count2));
    initial
        forever #25 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        n_mismatch += int'(got !== exp);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk) req <= '{a, 16'h0, 1'b0, 1'b1};
        q.push_back(e);
        @(posedge clk) req.rd <= 1'b0;
    endtask
    // Short high pulses with a long low tail, so the last edge settles before a stop.
    task automatic pulse(input int k, input int n);
        repeat (n)
        begin
            @(posedge clk) src[k] <= 1'b1;
            repeat (4) @(posedge clk) src[k] <= 1'b0;
        end
    endtask
    // Read data stands only in the cycle after the strobe.
    always @(posedge clk)
    begin
        if (rd_d)
            chk(rdata, q.pop_front());
        rd_d <= req.rd;
    end
    initial
    begin
        void'($urandom(32'hab2deb1f));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (3)
        begin
            w = 16'($urandom) & 16'h7fff;
            wr(4'h0, w);
            rd(4'h0, w & 16'ha37a);
            wr(4'h1, w);
            rd(4'h1, w & 16'ha372);
            rd(4'hf, 16'h0);
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(4'h0, 16'h8002 | (16'(k) << 8));
            pulse(k, 3);
            wr(4'h0, 16'h0002);
            pulse(k, 2);
            e1 += 16'h3;
            rd(4'h2, e1);
            chk(count1, e1);
        end
        for (int p = 0; p < 4; p++)
        begin
            wr(4'h0, 16'h8302 | (16'(p) << 4));
            pulse(3, 2 * dv[p]);
            wr(4'h0, 16'h0302);
            e1 += 16'h2;
            rd(4'h2, e1);
            chk(count1, e1);
        end
        wr(4'h0, 16'h8312);
        pulse(3, 4);
        wr(4'h0, 16'h8312);
        pulse(3, 7);
        wr(4'h0, 16'h0302);
        rd(4'h2, e1);
        chk(count1, e1);
        idle <= 1'b1;
        wr(4'h0, 16'ha000);
        repeat (6) @(posedge clk);
        wr(4'h0, 16'h2000);
        idle <= 1'b0;
        wr(4'h0, 16'h8040);
        @(posedge clk) gate1 <= 1'b1;
        repeat (5) @(posedge clk);
        gate1 <= 1'b0;
        repeat (2) @(posedge clk);
        wr(4'h0, 16'h0040);
        e1 += 16'h5;
        rd(4'h2, e1);
        chk(count1, e1);
        wr(4'h1, 16'h8002);
        pulse(0, 3);
        wr(4'h1, 16'h0000);
        rd(4'h3, 16'h3);
        chk(count2, 16'h3);
        wr(4'h0, 16'h0008);
        wr(4'h1, 16'h8000);
        wr(4'h0, 16'h8008);
        for (int i = 0; i < 70000 && count1 !== 16'hffff; i++)
            @(posedge clk);
        repeat (4) @(posedge clk);
        wr(4'h0, 16'h0008);
        wr(4'h1, 16'h0000);
        rd(4'h3, 16'h4);
        chk(count2, 16'h4);
        repeat (2) @(posedge clk);
        results;
    end
    initial
    begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        results;
    end
endmodule
`default_nettype wire

// ---- tpc_defs.svh ----
// Constant definitions for the cascadable timer pair control block.
// How it works
// RULE1 - Cascade bit joins timers into 32 bits
// RULE2 - Cascaded: second control register bits ignored
// RULE3 - Source bit picks Fosc/2 or extended source
// RULE4 - Control write while running resets prescaler
// RULE5 - Unimplemented bits read zero, ignore writes
// RULE6 - Software routes external clock pin first
// RULE7 - Prescale codes give 1,8,64,256 division
// RULE8 - Extended field picks pin, RC, other pin, oscillator
// RULE9 - Run bit starts counting, clear holds value
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH
`define TPC_ADDR_CTRL1     4'h0
`define TPC_ADDR_CTRL2     4'h1
`define TPC_ADDR_COUNT1    4'h2
`define TPC_ADDR_COUNT2    4'h3
`define TPC_BIT_RUN        15
`define TPC_BIT_IDLE       13
`define TPC_BIT_ESRC_HI    9
`define TPC_BIT_ESRC_LO    8
`define TPC_BIT_GATE       6
`define TPC_BIT_PS_HI      5
`define TPC_BIT_PS_LO      4
`define TPC_BIT_CASCADE    3
`define TPC_BIT_SRC        1
`define TPC_MASK_CTRL1     16'ha37a
`define TPC_MASK_CTRL2     16'ha372
`define TPC_CTRL_RESET     16'h0000
`define TPC_PS_MAX_1       8'h00
`define TPC_PS_MAX_8       8'h07
`define TPC_PS_MAX_64      8'h3f
`define TPC_PS_MAX_256     8'hff
`endif

// ---- tpc_pkg.sv ----
// Types shared by the timer pair control block.
package tpc_pkg;
    // Decoded view of one control register.
    typedef struct packed {
        logic       run;
        logic       idle_halt;
        logic [1:0] esrc;
        logic       gate;
        logic [1:0] prescale;
        logic       cascade;
        logic       src;
    } tpc_ctrl_t;
    // Register port request group.
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } tpc_req_t;
endpackage

// ---- tpc_prescaler.sv ----
// Prescaler that turns qualified input ticks into count enables.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.svh"
module tpc_prescaler
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       clear,
    input  wire logic       tick,
    input  wire logic [1:0] prescale,
    output logic            pulse
);
    import tpc_pkg::*;
    logic [7:0] count;  // Prescale counter.
    logic [7:0] limit;  // Terminal count for the chosen ratio.

    // Ratio decode.
    always_comb
    begin
        case (prescale)
            2'b11:   limit = `TPC_PS_MAX_256; // RULE7
            2'b10:   limit = `TPC_PS_MAX_64;
            2'b01:   limit = `TPC_PS_MAX_8;
            default: limit = `TPC_PS_MAX_1;
        endcase
    end

    // Counter advances per tick; a clear restarts the ratio from zero.
    always_ff @(posedge clk)
    begin
        if (rst || clear)
        begin
            count <= 8'h00; // RULE4
            pulse <= 1'b0;
        end
        else if (tick)
        begin
            pulse <= (count >= limit);
            count <= (count >= limit) ? 8'h00 : count + 8'h01;
        end
        else
        begin
            pulse <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- tpc_timer_pair.sv ----
// Control logic and counters for a cascadable pair of 16-bit timers.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.svh"
module tpc_timer_pair
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire tpc_pkg::tpc_req_t req,
    output logic [15:0]           rdata,
    input  wire logic             idle,
    input  wire logic             gate_in1,
    input  wire logic             gate_in2,
    input  wire logic             first_timer_clock_pin,
    input  wire logic             second_timer_clock_pin,
    input  wire logic             low_power_rc_osc,
    input  wire logic             secondary_osc,
    output logic [15:0]           count1,
    output logic [15:0]           count2
);
    import tpc_pkg::*;

    logic [15:0] first_timer_control;   // Control of the first timer and of the pair.
    logic [15:0] second_timer_control;  // Control of the second timer.
    logic [3:0]  prev_src;              // Pin and oscillator levels a cycle ago for edges.
    logic [3:0]  rise;                  // Rising edges of the four external sources.
    logic        tick1;                 // Qualified input tick, first timer.
    logic        tick2;                 // Qualified input tick, second timer.
    logic        clr1;                  // Prescaler restart, first timer.
    logic        clr2;                  // Prescaler restart, second timer.
    logic        inc1;                  // Count enable, first timer.
    logic        inc2;                  // Count enable, second timer.
    logic        cascade;               // Pair works as one 32-bit timer.
    tpc_ctrl_t   c1;                    // Decoded first control.
    tpc_ctrl_t   c2;                    // Decoded second control.

    // Decoding used for both control registers.
    function automatic tpc_ctrl_t decode(input logic [15:0] r);
        tpc_ctrl_t d;
        d.run       = r[`TPC_BIT_RUN];
        d.idle_halt = r[`TPC_BIT_IDLE];
        d.esrc      = r[`TPC_BIT_ESRC_HI:`TPC_BIT_ESRC_LO];
        d.gate      = r[`TPC_BIT_GATE];
        d.prescale  = r[`TPC_BIT_PS_HI:`TPC_BIT_PS_LO];
        d.cascade   = r[`TPC_BIT_CASCADE];
        d.src       = r[`TPC_BIT_SRC];
        return d;
    endfunction

    // Tick selection for one timer: internal rate is the system clock itself.
    function automatic logic pick(input tpc_ctrl_t c, input logic [3:0] e, input logic g, input logic own,
                                  input logic other);
        logic t;
        t = 1'b0;
        if (!c.src)
        begin
            // Internal rate: every clock, or only while the gate input is high.
            t = c.gate ? g : 1'b1; // RULE3
        end
        else
        begin
            // Extended source: one of four rising-edge streams.
            case (c.esrc) // RULE8
                2'b11:   t = own;
                2'b10:   t = e[2];
                2'b01:   t = other;
                default: t = e[3];
            endcase
        end
        return t;
    endfunction

    // Both registers share one decoder so the field positions live in one place.
    assign c1      = decode(first_timer_control);
    assign c2      = decode(second_timer_control);
    assign cascade = c1.cascade; // RULE1

    // Edge detection on external sources; routing the pin is software's job.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            // Sources idle low, so a low start avoids a false edge after reset.
            prev_src <= 4'h0;
        end
        else
        begin
            // Keep the last levels for the edge detector.
            prev_src <= {secondary_osc, low_power_rc_osc, second_timer_clock_pin, first_timer_clock_pin};
        end
    end
    // A source must stay low for at least one clock between edges, or an edge is lost.
    assign rise = {secondary_osc, low_power_rc_osc, second_timer_clock_pin, first_timer_clock_pin} & ~prev_src;

    // Idle halt stops a timer while the device idles.
    // The remaining terms pick the source and the run state.
    assign tick1 = c1.run && !(c1.idle_halt && idle)
                   && pick(c1, rise, gate_in1, rise[0], rise[1]); // RULE9
    // In cascade the second timer configuration is ignored entirely.
    assign tick2 = !cascade && c2.run && !(c2.idle_halt && idle)
                   && pick(c2, rise, gate_in2, rise[1], rise[0]); // RULE2

    // Any control write while running restarts the prescaler.
    assign clr1 = req.wr && req.addr == `TPC_ADDR_CTRL1 && c1.run; // RULE4
    // In cascade the second prescaler is held cleared so it cannot run on stale settings.
    assign clr2 = (req.wr && req.addr == `TPC_ADDR_CTRL2 && c2.run) || cascade;

    // First timer prescaler; in cascade it paces the whole pair.
    tpc_prescaler u_ps1
    (
        .clk      (clk),
        .rst      (rst),
        .clear    (clr1),
        .tick     (tick1),
        .prescale (c1.prescale),
        .pulse    (inc1)
    );

    // Second timer prescaler; it only matters while the pair is split.
    tpc_prescaler u_ps2
    (
        .clk      (clk),
        .rst      (rst),
        .clear    (clr2),
        .tick     (tick2),
        .prescale (c2.prescale),
        .pulse    (inc2)
    );

    // First control register; it also carries the pair's cascade setting.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            first_timer_control <= `TPC_CTRL_RESET;
        end
        else if (req.wr && req.addr == `TPC_ADDR_CTRL1)
        begin
            // Masking on write keeps unimplemented bits at zero for every later read.
            first_timer_control <= req.wdata & `TPC_MASK_CTRL1; // RULE5
        end
    end

    // Second control register; it stays writable in cascade but then steers nothing.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            second_timer_control <= `TPC_CTRL_RESET;
        end
        else if (req.wr && req.addr == `TPC_ADDR_CTRL2)
        begin
            // The cascade position is not implemented here and is masked with the rest.
            second_timer_control <= req.wdata & `TPC_MASK_CTRL2; // RULE5
        end
    end

    // Low counter; a software write wins over a count in the same cycle.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            // Counters start from zero after reset.
            count1 <= 16'h0000;
        end
        else if (req.wr && req.addr == `TPC_ADDR_COUNT1)
        begin
            // Direct load from software.
            count1 <= req.wdata;
        end
        else if (inc1)
        begin
            // Wraps from all ones to zero, which is the carry point in cascade.
            count1 <= count1 + 16'h0001; // RULE9
        end
    end

    // High counter; in cascade it steps when an increment finds the low half at all ones, even if a write loads the low half.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            // Counters start from zero after reset.
            count2 <= 16'h0000;
        end
        else if (req.wr && req.addr == `TPC_ADDR_COUNT2)
        begin
            // Direct load from software.
            count2 <= req.wdata;
        end
        else if (cascade ? (inc1 && count1 == 16'hffff) : inc2)
        begin
            // Carry from the low half, or the second timer's own enable when split.
            count2 <= count2 + 16'h0001; // RULE1
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata <= 16'h0000;
        end
        else if (req.rd)
        begin
            // Each address returns its register as last clocked.
            case (req.addr)
                `TPC_ADDR_CTRL1: rdata <= first_timer_control;
                `TPC_ADDR_CTRL2: rdata <= second_timer_control;
                `TPC_ADDR_COUNT1: rdata <= count1;
                `TPC_ADDR_COUNT2: rdata <= count2;
                default:          rdata <= 16'h0000;
            endcase
        end
        else
        begin
            // Zero outside the read cycle, so a stale value is never taken for data.
            rdata <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// ---- tpc_timer_pair_sva.sv ----
// Port assertions for the timer pair.
`timescale 1ns/1ps
`default_nettype none
module tpc_sva
(
    input wire logic              clk,
    input wire logic              rst,
    input wire tpc_pkg::tpc_req_t req,
    input wire logic [15:0]       rdata,
    input wire logic              first_timer_clock_pin,
    input wire logic [15:0]       count1,
    input wire logic [15:0]       count2
);
    import tpc_pkg::*;
    logic [15:0] c1; // Mirror of the first control register, since the mode is not visible at the ports.
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk)
        if (rst)
            c1 <= 16'h0;
        else if (req.wr && req.addr == 4'h0)
            c1 <= req.wdata & 16'ha37a;
    sequence s_hold(v);
        c1 == v [*4];
    endsequence
    a_rd_only: assert property (rdata != 16'h0 |-> $past(req.rd)) else $error("stray data");
    a_c1_zero: assert property ($past(req.rd) && $past(req.addr) == 4'h0 |-> !(rdata & 16'h5c85))
        else $error("spare bit");
    a_one_step: assert property ($changed(count1) && !$past(req.wr) |-> count1 == $past(count1) + 16'h1)
        else $error("jump");
    a_stop_hold: assert property (!c1[15] [*4] |=> $stable(count1)) else $error("count while stopped");
    a_pair_rate: assert property (s_hold(16'h8008) |-> count1 == $past(count1) + 16'h1) else $error("slow");
    a_pair_carry: assert property (s_hold(16'h8008) ##0 $changed(count2) |-> count1 == 16'h0)
        else $error("carry");
    a_div8_gap: assert property (s_hold(16'h8312) ##0 $changed(count1) |=> $stable(count1) [*7])
        else $error("too fast");
    a_pin_count: assert property (c1 == 16'h8302 && $rose(first_timer_clock_pin) |-> ##[1:4] $changed(count1))
        else $error("edge lost");
endmodule
bind tpc_timer_pair tpc_sva tpc_sva_inst (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .first_timer_clock_pin(first_timer_clock_pin), .count1(count1), .count2(count2));
`default_nettype wire
